// ### bench/irq_ctrl_model.sv
`timescale 1ns/1ps
module irq_ctrl_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // group lines in, acknowledge from service code
   input wire logic [15:0] irq_line,
   input wire logic [15:0] ack,
   // pending lines, held until acknowledged
   output logic [15:0] pend_q
);
   // latching means a one-cycle line pulse is never lost to the bench
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pend_q <= 16'h0000;
      end else begin
         pend_q <= (pend_q & ~ack) | irq_line;
      end
   end
endmodule // irq_ctrl_model

// ### bench/tb_irq_remap_group_mask.sv
`timescale 1ns/1ps
`include "irq_remap_defines.svh"
module tb_irq_remap_group_mask;
   logic clk, rst, bus_rvalid_q;
   logic [511:0] src_level;
   irq_remap_pkg::bus_req_t bus_req;
   logic [31:0] bus_rdata_q, a, b;
   logic [15:0] fabric_irq_line_q, ack, pend_q;
   logic [31:0] exp_q[$];
   int n_errors, check_count, k;
   logic [4:0] pos [16];
   logic [8:0] src [16];

   irq_remap_group_mask u_irq_remap_group_mask (
      .clk(clk), .rst(rst), .src_level(src_level), .bus_req(bus_req),
      .bus_rdata_q(bus_rdata_q), .bus_rvalid_q(bus_rvalid_q),
      .fabric_irq_line_q(fabric_irq_line_q));
   irq_ctrl_model u_irq_ctrl_model (
      .clk(clk), .rst(rst), .irq_line(fabric_irq_line_q), .ack(ack),
      .pend_q(pend_q));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   function automatic logic [15:0] at(logic [15:0] base, int i);
      return base + 16'(4 * i);
   endfunction

   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic finish_test();
      if (n_errors == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // for reads, data is the expected answer and goes on the queue
   task automatic access(logic rd, logic wr, logic [15:0] ad, logic [31:0] d);
      @(negedge clk);
      bus_req = '{rd: rd, wr: wr, addr: ad, wdata: d};
      if (rd) begin
         exp_q.push_back(d);
      end
      @(negedge clk);
      bus_req = '0;
   endtask

   always @(negedge clk) begin
      if (!rst && bus_rvalid_q === 1'b1) begin
         if (exp_q.size() == 0) begin
            check("pending reads", 32'(exp_q.size()), 32'h1);
         end else begin
            check("read data", bus_rdata_q, exp_q.pop_front());
         end
      end
   end

   initial begin
      #(100 * 4000);
      n_errors++;
      finish_test();
   end

   initial begin
      rst = 1'b1;
      src_level = '0;
      bus_req = '0;
      ack = '0;
      n_errors = 0;
      check_count = 0;
      void'($urandom(68));
      repeat (16) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      k = $urandom_range(511);
      access(1'b1, 1'b0, at(`RT_BASE, k), 32'h0);
      access(1'b1, 1'b0, at(`EN_BASE, 3), 32'h0);
      access(1'b1, 1'b0, 16'h1c80, 32'h0);
      a = $urandom;
      b = $urandom;
      access(1'b0, 1'b1, at(`EN_BASE, 7), a);
      access(1'b0, 1'b1, at(`EN_BASE, 7), b);
      access(1'b1, 1'b0, at(`EN_BASE, 7), a | b);
      access(1'b1, 1'b0, at(`EN_BASE, 7), a | b);
      access(1'b0, 1'b1, at(`DIS_BASE, 7), a);
      access(1'b1, 1'b0, at(`EN_BASE, 7), b & ~a);
      access(1'b1, 1'b0, at(`DIS_BASE, 7), b & ~a);
      access(1'b1, 1'b0, at(`EN_BASE, 7), 32'h0);
      access(1'b0, 1'b1, at(`RT_BASE, k), 32'h7fff_ffff);
      access(1'b1, 1'b0, at(`RT_BASE, k), 32'h0);
      // source block and target group differ, so any-to-any is exercised
      for (int g = 0; g < 16; g++) begin
         pos[g] = 5'($urandom);
         src[g] = {4'(15 - g), 5'($urandom)};
         a = {1'b1, 19'h0, 4'(g), 3'h0, pos[g]};
         access(1'b0, 1'b1, at(`RT_BASE, int'(src[g])), a);
         access(1'b1, 1'b0, at(`RT_BASE, int'(src[g])), a);
         access(1'b0, 1'b1, at(`EN_BASE, g), 32'h1 << pos[g]);
      end
      for (int g = 0; g < 16; g++) begin
         src_level = '0;
         src_level[src[g]] = 1'b1;
         @(negedge clk);
         check("line", 32'(fabric_irq_line_q), 32'h1 << g);
      end
      // the controller latches the last line one edge after it rises
      @(negedge clk);
      check("pending", 32'(pend_q), 32'h0000_ffff);
      ack = '1;
      src_level = '1;
      @(negedge clk);
      ack = '0;
      check("all lines", 32'(fabric_irq_line_q), 32'h0000_ffff);
      access(1'b1, 1'b0, at(`DIS_BASE, 5), 32'h1 << pos[5]);
      @(negedge clk);
      check("masked", 32'(fabric_irq_line_q), 32'h0000_ffdf);
      access(1'b0, 1'b1, at(`RT_BASE, int'(src[3])), 32'h0);
      @(negedge clk);
      check("unrouted", 32'(fabric_irq_line_q), 32'h0000_ffd7);
      rst = 1'b1;
      @(negedge clk);
      check("reset lines", 32'(fabric_irq_line_q), 32'h0);
      rst = 1'b0;
      access(1'b1, 1'b0, at(`RT_BASE, int'(src[0])), 32'h0);
      access(1'b1, 1'b0, at(`EN_BASE, 0), 32'h0);
      check("lines after reset", 32'(fabric_irq_line_q), 32'h0);
      repeat (3) @(negedge clk);
      check("reads left", 32'(exp_q.size()), 32'h0);
      finish_test();
   end
endmodule // tb_irq_remap_group_mask

// ### design/irq_remap_defines.svh
`ifndef IRQ_REMAP_DEFINES_SVH
`define IRQ_REMAP_DEFINES_SVH

// byte offsets of the three register vectors
`define RT_BASE 16'h1400
`define RT_SPAN 16'h0800
`define EN_BASE 16'h1c00
`define EN_SPAN 16'h0040
`define DIS_BASE 16'h1c40
`define DIS_SPAN 16'h0040

// route entry word layout
`define MAP_BIT 31
`define GRP_LSB 8
`define POS_LSB 0

// reset values
`define ENTRY_RST 10'h000
`define EN_RST 32'h0000_0000

// cycles from a taken read to its answer
`define READ_LAT 2

`endif

// ### design/irq_remap_group_mask.sv
`timescale 1ns/1ps
`include "irq_remap_defines.svh"

// Summary of operation
// - group n drives interrupt line n, fixed for all sixteen groups
// - one routing entry per source, 512 in all, any group reachable
// - each entry holds a routed flag, a target group and a bit position
// - entries form a 512-word read/write vector, one word per source
// - unrouted sources never interrupt; their group and position read zero
// - a routed source appears in its named group at its named bit
// - each group has 32 enable bits, an enable and a disable register
// - writing ones to the enable register enables those sources
// - reading the enable register returns enables and changes nothing
// - writing ones to the disable register disables those sources
// - reading the disable register returns enables then clears them all
// - each group ORs its routed, enabled sources into one output
// - source address 0 to 511 selects its routing entry

module irq_remap_group_mask #(
   parameter int NUM_SRC = 512,
   parameter int NUM_GRP = 16,
   parameter int GRP_W = 32
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // interrupt source levels, same clock domain
   input wire logic [NUM_SRC-1:0] src_level,
   // load/store port
   input wire irq_remap_pkg::bus_req_t bus_req,
   output logic [31:0] bus_rdata_q,
   output logic bus_rvalid_q,
   // one line per group to the processor interrupt controller
   output logic [NUM_GRP-1:0] fabric_irq_line_q
);

   localparam int IW = $clog2(NUM_SRC);
   localparam int GW = $clog2(NUM_GRP);

   if (NUM_SRC != 512 || NUM_GRP != 16 || GRP_W != 32) begin : g_chk
      $error("route entry fields fit only 512 sources, 16 groups of 32");
   end

   if (`READ_LAT != 2) begin : g_lat_chk
      $error("read pipeline is built for a two-cycle answer");
   end

   function automatic logic in_span(input logic [15:0] a,
                                    input logic [15:0] base,
                                    input logic [15:0] span);
      in_span = (a >= base) && (a < base + span) && (a[1:0] == 2'b00);
   endfunction

   function automatic logic [15:0] word_of(input logic [15:0] a,
                                           input logic [15:0] base);
      word_of = (a - base) >> 2;
   endfunction

   function automatic logic [31:0] entry_word(
      input irq_remap_pkg::route_entry_t e);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[`MAP_BIT] = e.map;
      w[`GRP_LSB +: 4] = e.grp;
      w[`POS_LSB +: 5] = e.pos;
      entry_word = w;
   endfunction

   // ---- address decode
   wire logic rd = bus_req.rd;
   wire logic wr = bus_req.wr & ~bus_req.rd;
   wire logic [15:0] addr = bus_req.addr;
   wire logic [31:0] wdata = bus_req.wdata;
   wire logic hit_rt = in_span(addr, `RT_BASE, `RT_SPAN);
   wire logic hit_en = in_span(addr, `EN_BASE, `EN_SPAN);
   wire logic hit_dis = in_span(addr, `DIS_BASE, `DIS_SPAN);
   wire logic [15:0] rt_word = word_of(addr, `RT_BASE);
   wire logic [15:0] en_word = word_of(addr, `EN_BASE);
   wire logic [15:0] dis_word = word_of(addr, `DIS_BASE);
   wire logic [IW-1:0] rt_idx = rt_word[IW-1:0];
   wire logic [GW-1:0] grp_idx = hit_en ? en_word[GW-1:0]
                                        : dis_word[GW-1:0];

   // ---- route table
   irq_remap_pkg::route_entry_t wr_entry;
   irq_remap_pkg::route_entry_t rt_rd_q;
   irq_remap_pkg::route_entry_t [NUM_SRC-1:0] tbl;
   wire logic wr_map = wdata[`MAP_BIT];
   // an unrouted entry stores zero fields so it reads back zero
   assign wr_entry.map = wr_map;
   assign wr_entry.grp = wr_map ? wdata[`GRP_LSB +: 4] : 4'h0;
   assign wr_entry.pos = wr_map ? wdata[`POS_LSB +: 5] : 5'h00;
   wire logic rt_we = wr & hit_rt;

   route_table #(
      .DEPTH(NUM_SRC)
   ) u_table (
      .clk(clk),
      .rst(rst),
      .wr_en(rt_we),
      .wr_idx(rt_idx),
      .wr_entry(wr_entry),
      .rd_idx(rt_idx),
      .rd_entry_q(rt_rd_q),
      .table_q(tbl)
   );

   // ---- routing network
   logic [NUM_GRP-1:0][GRP_W-1:0] routed;
   always_comb begin
      routed = '0;
      for (int k = 0; k < NUM_SRC; k++) begin
         if (tbl[k].map) begin
            routed[tbl[k].grp][tbl[k].pos] = routed[tbl[k].grp][tbl[k].pos]
                                             | src_level[k];
         end
      end
   end

   // ---- enable bits
   logic [NUM_GRP-1:0][GRP_W-1:0] en_q;
   logic [NUM_GRP-1:0][GRP_W-1:0] en_d;
   wire logic en_set = wr & hit_en;
   wire logic en_clr = wr & hit_dis;
   // a disable read snapshots and clears in the same edge: nothing lost
   wire logic en_drain = rd & hit_dis;
   always_comb begin
      en_d = en_q;
      if (en_set) begin
         en_d[grp_idx] = en_q[grp_idx] | wdata;
      end else if (en_clr) begin
         en_d[grp_idx] = en_q[grp_idx] & ~wdata;
      end else if (en_drain) begin
         en_d[grp_idx] = `EN_RST;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         en_q <= '0;
      end else begin
         en_q <= en_d;
      end
   end

   // ---- group outputs
   logic [NUM_GRP-1:0] irq_d;
   always_comb begin
      for (int g = 0; g < NUM_GRP; g++) begin
         irq_d[g] = |(routed[g] & en_q[g]);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fabric_irq_line_q <= '0;
      end else begin
         fabric_irq_line_q <= irq_d;
      end
   end

   // ---- read pipeline, two cycles for every read
   irq_remap_pkg::rd_src_t src_q;
   irq_remap_pkg::rd_src_t src_d;
   logic [31:0] hold_q;
   logic rd_p1_q;
   assign src_d = !rd ? irq_remap_pkg::SRC_NONE :
                  hit_rt ? irq_remap_pkg::SRC_ROUTE :
                  (hit_en || hit_dis) ? irq_remap_pkg::SRC_EN :
                  irq_remap_pkg::SRC_NONE;
   wire logic [31:0] rdata_d = (src_q == irq_remap_pkg::SRC_ROUTE) ?
                               entry_word(rt_rd_q) :
                               (src_q == irq_remap_pkg::SRC_EN) ? hold_q :
                               32'h0000_0000;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         src_q <= irq_remap_pkg::SRC_NONE;
         hold_q <= 32'h0000_0000;
         rd_p1_q <= 1'b0;
      end else begin
         src_q <= src_d;
         hold_q <= en_q[grp_idx];
         rd_p1_q <= rd;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bus_rdata_q <= 32'h0000_0000;
         bus_rvalid_q <= 1'b0;
      end else begin
         bus_rdata_q <= rdata_d;
         bus_rvalid_q <= rd_p1_q;
      end
   end

   // ---- checks
   wire logic en_rd = rd & hit_en;

   // expected values are taken at the request edge, not at the answer
   sequence read_answer_s(logic [31:0] v);
      ##2 bus_rvalid_q && (bus_rdata_q == $past(v, 2));
   endsequence

   // the group index is only on the bus in the request cycle
   sequence drained_s(logic [GW-1:0] g);
      ##1 (en_q[$past(g)] == 32'h0000_0000);
   endsequence

   read_lat_a: assert property (@(posedge clk) disable iff (rst)
      rd |-> ##2 bus_rvalid_q)
      else $error("read answer not two cycles after request");

   en_set_a: assert property (@(posedge clk) disable iff (rst)
      en_set |=> en_q[$past(grp_idx)] ==
                 ($past(en_q[grp_idx]) | $past(wdata)))
      else $error("enable write did not set written ones");

   en_clr_a: assert property (@(posedge clk) disable iff (rst)
      en_clr |=> en_q[$past(grp_idx)] ==
                 ($past(en_q[grp_idx]) & ~$past(wdata)))
      else $error("disable write did not clear written ones");

   en_read_a: assert property (@(posedge clk) disable iff (rst)
      en_rd |-> read_answer_s(en_q[grp_idx]) and
                ##1 (en_q == $past(en_q)))
      else $error("enable read wrong or altered state");

   dis_read_a: assert property (@(posedge clk) disable iff (rst)
      en_drain |-> drained_s(grp_idx) and read_answer_s(en_q[grp_idx]))
      else $error("disable read did not return then clear enables");

   unmap_zero_a: assert property (@(posedge clk) disable iff (rst)
      (rt_we && !wr_map) |=> (tbl[$past(rt_idx)] == '0))
      else $error("unrouted entry kept group or position bits");

   route_rd_a: assert property (@(posedge clk) disable iff (rst)
      (rd && hit_rt) |-> read_answer_s({tbl[rt_idx].map, 19'h0_0000,
         tbl[rt_idx].grp, 3'h0, tbl[rt_idx].pos}))
      else $error("route entry read back wrong");

   irq_on_a: assert property (@(posedge clk) disable iff (rst)
      (|(routed[0] & en_q[0])) |=> fabric_irq_line_q[0])
      else $error("group 0 line not raised for enabled source");

   irq_off_a: assert property (@(posedge clk) disable iff (rst)
      (routed == '0) |=> (fabric_irq_line_q == '0))
      else $error("line raised with no routed source active");

   reset_clear_a: assert property (@(posedge clk)
      rst |=> (en_q == '0) && (fabric_irq_line_q == '0))
      else $error("reset did not clear enables and lines");

   rvalid_src_a: assert property (@(posedge clk) disable iff (rst)
      bus_rvalid_q |-> $past(rd, 2))
      else $error("read answer without a read request");

   // enables and routes only move on a request that targets them
   idle_hold_a: assert property (@(posedge clk) disable iff (rst)
      (!rt_we && !en_set && !en_clr && !en_drain) |=>
         (en_q == $past(en_q)) && (tbl == $past(tbl)))
      else $error("state changed without a request");

   route_wr_a: assert property (@(posedge clk) disable iff (rst)
      (rt_we && wr_map) |=> (tbl[$past(rt_idx)] ==
         {1'b1, $past(wdata[`GRP_LSB +: 4]), $past(wdata[`POS_LSB +: 5])}))
      else $error("routed entry not stored as written");

   unmap_read_a: assert property (@(posedge clk) disable iff (rst)
      (rd && hit_rt && !tbl[rt_idx].map) |-> read_answer_s(32'h0000_0000))
      else $error("unrouted entry did not read zero");

   no_reg_read_a: assert property (@(posedge clk) disable iff (rst)
      (rd && !hit_rt && !hit_en && !hit_dis) |->
         read_answer_s(32'h0000_0000))
      else $error("read of an unmapped address not zero");

   // cleared enables reach the line one edge after the drain
   dis_line_a: assert property (@(posedge clk) disable iff (rst)
      en_drain |=> ##1 !fabric_irq_line_q[$past(grp_idx, 2)])
      else $error("line stayed up after its enables were drained");

   reset_bus_a: assert property (@(posedge clk)
      rst |=> !bus_rvalid_q && (bus_rdata_q == 32'h0000_0000))
      else $error("reset did not quiet the read port");

   for (genvar g = 0; g < NUM_GRP; g++) begin : g_line
      line_up_a: assert property (@(posedge clk) disable iff (rst)
         (|(routed[g] & en_q[g])) |=> fabric_irq_line_q[g])
         else $error("group line not raised for its own sources");
      line_down_a: assert property (@(posedge clk) disable iff (rst)
         !(|(routed[g] & en_q[g])) |=> !fabric_irq_line_q[g])
         else $error("group line raised with no enabled source");
   end

endmodule // irq_remap_group_mask

// ### design/irq_remap_pkg.sv
package irq_remap_pkg;

   typedef struct packed {
      logic map;
      logic [3:0] grp;
      logic [4:0] pos;
   } route_entry_t;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [15:0] addr;
      logic [31:0] wdata;
   } bus_req_t;

   typedef enum logic [1:0] {
      SRC_NONE,
      SRC_ROUTE,
      SRC_EN
   } rd_src_t;

endpackage

// ### design/route_table.sv
`timescale 1ns/1ps
`include "irq_remap_defines.svh"

module route_table #(
   parameter int DEPTH = 512
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // write port
   input wire logic wr_en,
   input wire logic [$clog2(DEPTH)-1:0] wr_idx,
   input wire irq_remap_pkg::route_entry_t wr_entry,
   // read port, data one cycle later
   input wire logic [$clog2(DEPTH)-1:0] rd_idx,
   output irq_remap_pkg::route_entry_t rd_entry_q,
   // every entry at once, for the routing network
   output irq_remap_pkg::route_entry_t [DEPTH-1:0] table_q
);

   // all entries live in flops: routing needs every one of them each cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int k = 0; k < DEPTH; k++) begin
            table_q[k] <= `ENTRY_RST;
         end
      end else if (wr_en) begin
         table_q[wr_idx] <= wr_entry;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_entry_q <= `ENTRY_RST;
      end else begin
         rd_entry_q <= table_q[rd_idx];
      end
   end

endmodule // route_table
